// ===== design/tmr_defines.vh
/*
 * register map, field positions and reset values of the timer option
 * and interrupt register block.
 * assumes inclusion by bare name from the block's design file.
 */
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define TMR_T1_PENDING_ADDR 32'h4000_a800
`define TMR_T2_PENDING_ADDR 32'h4000_a804
`define TMR_T1_MISSED_ADDR 32'h4000_a818
`define TMR_T2_MISSED_ADDR 32'h4000_a81c
`define TMR_T1_ENABLE_ADDR 32'h4000_a840
`define TMR_T2_ENABLE_ADDR 32'h4000_a844
`define TMR_T2_OPTIONS_ADDR 32'h4000_f050

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_OPT_CH4_SEL 7
`define TMR_OPT_CH3_SEL 6
`define TMR_OPT_CH2_SEL 5
`define TMR_OPT_CH1_SEL 4
`define TMR_OPT_RSVD 3
`define TMR_OPT_MASK_EN 2
`define TMR_OPT_TRIG_HI 1
`define TMR_OPT_TRIG_LO 0
`define TMR_IRQ_TRIGGER 6
`define TMR_IRQ_CC_HI 4
`define TMR_IRQ_CC_LO 1
`define TMR_IRQ_UPDATE 0
`define TMR_MISS_CC_HI 12
`define TMR_MISS_CC_LO 9

// ****************************************************************
// reset values and trigger select codes
// ****************************************************************
`define TMR_RESET_VALUE 32'h0000_0000
`define TMR_OPT_WIDTH 8
`define TMR_IRQ_WIDTH 7
`define TMR_TRIG_PCLK 2'h0
`define TMR_TRIG_1KHZ 2'h1
`define TMR_TRIG_32KHZ 2'h2
`define TMR_TRIG_PIN 2'h3

`endif

// ===== design/tmr_option_irq_regs.v
/*
 * option register of timer 2 (channel pin routing, external trigger
 * select and clock masking) and the enable, pending and missed
 * interrupt registers of both timers, as an ahb-lite slave.
 * assumes timer cores on hclk supply one-cycle event pulses, and that
 * pins and slow clocks arrive asynchronously.
 */
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "tmr_defines.vh"

module tmr_option_irq_regs
(
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // timer events, one-cycle pulses: {trigger, cc4..cc1, update}
   input wire [5:0] t1_events,
   input wire [5:0] t2_events,
   // timer 2 channel signals toward the gpio pins
   input wire [3:0] t2_chan_out,
   output reg port_a_bit0,
   output reg port_a_bit1,
   output reg port_a_bit2,
   output reg port_a_bit3,
   output reg port_b_bit1,
   output reg port_b_bit2,
   output reg port_b_bit3,
   output reg port_b_bit4,
   // external trigger sources
   input wire ext_clock_pin,
   input wire ext_clock_mask_input,
   input wire clk_1khz,
   input wire clk_32khz,
   output reg t2_ext_trigger,
   // interrupts
   output reg t1_irq,
   output reg t2_irq
);

   // ****************************************************************
   // ahb address phase capture
   // ****************************************************************
   reg wr_pend_q;
   reg rd_pend_q;
   reg [31:0] addr_q;
   wire take;

   assign take = hsel & hready & htrans[1];

   // latch the address phase; data phase always completes in one cycle
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= `TMR_RESET_VALUE;
      end
      else
      begin
         wr_pend_q <= take & hwrite;
         rd_pend_q <= take & ~hwrite;
         addr_q <= take ? haddr : addr_q;
      end
   end

   // ****************************************************************
   // register storage
   // ****************************************************************
   reg [7:0] opt_q;
   wire [6:0] en_w [0:1];
   wire [6:0] pend_w [0:1];
   wire [3:0] miss_w [0:1];
   wire [5:0] ev [0:1];

   assign ev[0] = t1_events;
   assign ev[1] = t2_events;

   // option register, only timer 2's lives here
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         opt_q <= 8'h00;
      else if (wr_pend_q && addr_q == `TMR_T2_OPTIONS_ADDR)
         opt_q <= hwdata[7:0];
   end

   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1)
      begin : g_tmr
         wire wr_en;
         wire wr_pend;
         wire wr_miss;
         wire [6:0] set_pend;
         wire [6:0] clr_pend;
         wire [3:0] set_miss;
         wire [3:0] clr_miss;
         // each timer owns its flops, so every register has a single driver
         reg [6:0] en_q;
         reg [6:0] pend_q;
         reg [3:0] miss_q;

         assign en_w[t] = en_q;
         assign pend_w[t] = pend_q;
         assign miss_w[t] = miss_q;
         assign wr_en = wr_pend_q && addr_q == (t ? `TMR_T2_ENABLE_ADDR : `TMR_T1_ENABLE_ADDR);
         assign wr_pend = wr_pend_q && addr_q == (t ? `TMR_T2_PENDING_ADDR : `TMR_T1_PENDING_ADDR);
         assign wr_miss = wr_pend_q && addr_q == (t ? `TMR_T2_MISSED_ADDR : `TMR_T1_MISSED_ADDR);
         // event bits mapped to flag positions, bit 5 unused
         assign set_pend = {ev[t][5], 1'b0, ev[t][4:0]};
         assign clr_pend = wr_pend ? (hwdata[6:0] & 7'h5f) : 7'h00;
         // a channel event landing on a still-pending flag is missed
         assign set_miss = ev[t][4:1] & pend_q[4:1];
         assign clr_miss = wr_miss ? hwdata[12:9] : 4'h0;

         // set wins over a same-cycle write-one clear
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               en_q <= 7'h00;
               pend_q <= 7'h00;
               miss_q <= 4'h0;
            end
            else
            begin
               if (wr_en)
                  en_q <= hwdata[6:0] & 7'h5f;
               pend_q <= (pend_q & ~clr_pend) | set_pend;
               miss_q <= (miss_q & ~clr_miss) | set_miss;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // read mux and bus response
   // ****************************************************************
   reg [31:0] rd_d;

   // reserved pending and missed bits read as zero here, which is legal
   always @*
   begin
      rd_d = `TMR_RESET_VALUE;
      case (haddr)
         `TMR_T1_PENDING_ADDR: rd_d = {25'h0, pend_w[0]};
         `TMR_T2_PENDING_ADDR: rd_d = {25'h0, pend_w[1]};
         `TMR_T1_MISSED_ADDR: rd_d = {19'h0, miss_w[0], 9'h0};
         `TMR_T2_MISSED_ADDR: rd_d = {19'h0, miss_w[1], 9'h0};
         `TMR_T1_ENABLE_ADDR: rd_d = {25'h0, en_w[0]};
         `TMR_T2_ENABLE_ADDR: rd_d = {25'h0, en_w[1]};
         `TMR_T2_OPTIONS_ADDR: rd_d = {24'h0, opt_q};
         default: rd_d = `TMR_RESET_VALUE;
      endcase
   end

   // read data registered at address phase, valid in the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= `TMR_RESET_VALUE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hrdata <= (take & ~hwrite) ? rd_d : `TMR_RESET_VALUE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // interrupt outputs
   // ****************************************************************
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         t1_irq <= 1'b0;
         t2_irq <= 1'b0;
      end
      else
      begin
         t1_irq <= |(pend_w[0] & en_w[0]);
         t2_irq <= |(pend_w[1] & en_w[1]);
      end
   end

   // ****************************************************************
   // channel pin routing
   // ****************************************************************
   // unselected pin is held low so it never carries a stale channel
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         port_a_bit0 <= 1'b0;
         port_a_bit1 <= 1'b0;
         port_a_bit2 <= 1'b0;
         port_a_bit3 <= 1'b0;
         port_b_bit1 <= 1'b0;
         port_b_bit2 <= 1'b0;
         port_b_bit3 <= 1'b0;
         port_b_bit4 <= 1'b0;
      end
      else
      begin
         port_a_bit2 <= t2_chan_out[3] & ~opt_q[`TMR_OPT_CH4_SEL];
         port_b_bit4 <= t2_chan_out[3] & opt_q[`TMR_OPT_CH4_SEL];
         port_a_bit1 <= t2_chan_out[2] & ~opt_q[`TMR_OPT_CH3_SEL];
         port_b_bit3 <= t2_chan_out[2] & opt_q[`TMR_OPT_CH3_SEL];
         port_a_bit3 <= t2_chan_out[1] & ~opt_q[`TMR_OPT_CH2_SEL];
         port_b_bit2 <= t2_chan_out[1] & opt_q[`TMR_OPT_CH2_SEL];
         port_a_bit0 <= t2_chan_out[0] & ~opt_q[`TMR_OPT_CH1_SEL];
         port_b_bit1 <= t2_chan_out[0] & opt_q[`TMR_OPT_CH1_SEL];
      end
   end

   // ****************************************************************
   // external trigger select
   // ****************************************************************
   // three-stage synchronisers for pins and slow clocks
   reg [2:0] sync_pin_q;
   reg [2:0] sync_msk_q;
   reg [2:0] sync_1k_q;
   reg [2:0] sync_32k_q;
   reg pin_q;
   reg msk_q;
   reg k1_q;
   reg k32_q;
   reg trig_d;

   // a level counts only once stages two and three agree
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_pin_q <= 3'h0;
         sync_msk_q <= 3'h0;
         sync_1k_q <= 3'h0;
         sync_32k_q <= 3'h0;
         pin_q <= 1'b0;
         msk_q <= 1'b0;
         k1_q <= 1'b0;
         k32_q <= 1'b0;
      end
      else
      begin
         sync_pin_q <= {sync_pin_q[1:0], ext_clock_pin};
         sync_msk_q <= {sync_msk_q[1:0], ext_clock_mask_input};
         sync_1k_q <= {sync_1k_q[1:0], clk_1khz};
         sync_32k_q <= {sync_32k_q[1:0], clk_32khz};
         if (sync_pin_q[1] == sync_pin_q[2])
            pin_q <= sync_pin_q[2];
         if (sync_msk_q[1] == sync_msk_q[2])
            msk_q <= sync_msk_q[2];
         if (sync_1k_q[1] == sync_1k_q[2])
            k1_q <= sync_1k_q[2];
         if (sync_32k_q[1] == sync_32k_q[2])
            k32_q <= sync_32k_q[2];
      end
   end

   // pclk choice is passed as a constant high; the core counts its edges
   always @*
   begin
      case (opt_q[`TMR_OPT_TRIG_HI:`TMR_OPT_TRIG_LO])
         `TMR_TRIG_PCLK: trig_d = 1'b1;
         `TMR_TRIG_1KHZ: trig_d = k1_q;
         `TMR_TRIG_32KHZ: trig_d = k32_q;
         `TMR_TRIG_PIN: trig_d = pin_q & (msk_q | ~opt_q[`TMR_OPT_MASK_EN]);
         default: trig_d = 1'b0;
      endcase
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         t2_ext_trigger <= 1'b0;
      else
         t2_ext_trigger <= trig_d;
   end

endmodule // tmr_option_irq_regs

// ===== test/test_tmr_option_irq_regs.sv
/* self-checking bench for the timer option and irq register block.
   assumes the design on one 250 mhz clock with a zero-wait ahb-lite slave. */
`timescale 1ns/1ns
module test_tmr_option_irq_regs;
   // ****************************************************************
   // signals, dut and tasks
   // ****************************************************************
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, d, r;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [5:0] t1_events = 0, t2_events = 0;
   logic [3:0] t2_chan_out = 0;
   logic ext_clock_pin = 0, ext_clock_mask_input = 0, clk_1khz = 0, clk_32khz = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, t2_ext_trigger, t1_irq, t2_irq;
   wire port_a_bit0, port_a_bit1, port_a_bit2, port_a_bit3;
   wire port_b_bit1, port_b_bit2, port_b_bit3, port_b_bit4;
   wire hready = hreadyout;
   integer miscompares = 0, checks_done = 0, cyc = 0, i, j, t, p;
   logic [31:0] adr [0:7] = '{32'h4000_a800, 32'h4000_a804, 32'h4000_a818, 32'h4000_a81c,
      32'h4000_a840, 32'h4000_a844, 32'h4000_f050, 32'h4000_a808};
   tmr_option_irq_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .t1_events(t1_events),
      .t2_events(t2_events), .t2_chan_out(t2_chan_out), .port_a_bit0(port_a_bit0),
      .port_a_bit1(port_a_bit1), .port_a_bit2(port_a_bit2), .port_a_bit3(port_a_bit3),
      .port_b_bit1(port_b_bit1), .port_b_bit2(port_b_bit2), .port_b_bit3(port_b_bit3),
      .port_b_bit4(port_b_bit4), .ext_clock_pin(ext_clock_pin),
      .ext_clock_mask_input(ext_clock_mask_input), .clk_1khz(clk_1khz),
      .clk_32khz(clk_32khz), .t2_ext_trigger(t2_ext_trigger), .t1_irq(t1_irq),
      .t2_irq(t2_irq));
   // free-running bus clock
   initial
   begin
      forever #2 hclk = ~hclk;
   end
   task print_verdict;
   begin
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   // guard against a slave that never answers
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares = miscompares + 1;
         print_verdict;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // one single transfer, entered just after a rising edge
   task xfer(input w, input [31:0] a, input [31:0] wd);
   begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
   end
   endtask
   task rdchk(input [31:0] a, input [31:0] exp);
   begin
      xfer(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   end
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      d = $urandom(63258);
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 8; i++) rdchk(adr[i], 32'h0000_0000);
      chk({hreadyout, hresp}, 32'h0000_0002);
      // read-write storage; unmapped place keeps nothing
      for (i = 4; i < 8; i++)
      begin
         d = $urandom;
         if (i == 6) d[3] = 1'b0;
         xfer(1'b1, adr[i], d);
         rdchk(adr[i], d & ((i == 6) ? 32'h0000_00ff : (i == 7) ? 0 : 32'h0000_005f));
      end
      xfer(1'b1, adr[4], 32'h0000_005f);
      xfer(1'b1, adr[5], 32'h0000_0000);
      // two back-to-back events: pending, then missed for cc1..cc4 only; timer 2 masked
      for (t = 0; t < 2; t++)
         for (j = 0; j < 6; j++)
         begin
            p = (j == 5) ? 6 : j;
            if (t) t2_events <= 6'h01 << j;
            else t1_events <= 6'h01 << j;
            repeat (2) @(posedge hclk);
            t1_events <= 6'h00;
            t2_events <= 6'h00;
            repeat (2) @(posedge hclk);
            chk(t ? t2_irq : t1_irq, !t);
            rdchk(adr[t], 1 << p);
            rdchk(adr[t + 2], (j > 0 && j < 5) ? 1 << (j + 8) : 0);
            xfer(1'b1, adr[t], 1 << p);
            xfer(1'b1, adr[t + 2], 32'hffff_ffff);
            rdchk(adr[t], 32'h0000_0000);
            rdchk(adr[t + 2], 32'h0000_0000);
            chk(t ? t2_irq : t1_irq, 0);
         end
      // random pin routing; channel levels ride in the upper bits
      for (i = 0; i < 8; i++)
      begin
         d = $urandom;
         d[3] = 1'b0;
         xfer(1'b1, adr[6], d);
         t2_chan_out <= d[11:8];
         repeat (3) @(posedge hclk);
         chk({port_a_bit0, port_a_bit1, port_a_bit2, port_a_bit3, port_b_bit1, port_b_bit2,
            port_b_bit3, port_b_bit4}, {d[8] & ~d[4], d[10] & ~d[6], d[11] & ~d[7],
            d[9] & ~d[5], d[8] & d[4], d[9] & d[5], d[10] & d[6], d[11] & d[7]});
      end
      // every trigger code, mask on and off, random source levels
      for (i = 0; i < 32; i++)
      begin
         d = $urandom;
         xfer(1'b1, adr[6], i & 7);
         ext_clock_pin <= d[4];
         ext_clock_mask_input <= d[5];
         clk_1khz <= d[6];
         clk_32khz <= d[7];
         repeat (6) @(posedge hclk);
         p = i & 3;
         chk(t2_ext_trigger, (p == 0) ? 1 : (p == 1) ? d[6] : (p == 2) ? d[7] :
            d[4] & (d[5] | ~i[2]));
      end
      print_verdict;
   end
endmodule // test_tmr_option_irq_regs

// ===== test/tmr_option_irq_regs_monitor.sv
/* checker for the timer option and irq register block.
   assumes binding onto the design top and the register map header. */
`timescale 1ns/1ns
`include "tmr_defines.vh"
module tmr_option_irq_regs_monitor
(
   // clock, reset and bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hwdata,
   // pins and trigger sources
   input wire [3:0] t2_chan_out,
   input wire port_a_bit0,
   input wire port_a_bit1,
   input wire port_a_bit2,
   input wire port_a_bit3,
   input wire port_b_bit1,
   input wire port_b_bit2,
   input wire port_b_bit3,
   input wire port_b_bit4,
   input wire ext_clock_pin,
   input wire ext_clock_mask_input,
   input wire clk_1khz,
   input wire t2_ext_trigger
);
   // ****************************************************************
   // option mirror and assertions
   // ****************************************************************
   reg wr_q;
   reg [7:0] opt_q;
   // option reg is not a port, so follow bus writes to it
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         opt_q <= 8'h00;
      end
      else
      begin
         wr_q <= hsel & hready & htrans[1] & hwrite & (haddr == `TMR_T2_OPTIONS_ADDR);
         if (wr_q)
            opt_q <= hwdata[7:0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_chan4_route: assert property ($past(hresetn) |-> {port_a_bit2, port_b_bit4} ==
      {$past(t2_chan_out[3] & ~opt_q[7]), $past(t2_chan_out[3] & opt_q[7])})
      else $error("channel 4 routing wrong");
   a_chan3_route: assert property ($past(hresetn) |-> {port_a_bit1, port_b_bit3} ==
      {$past(t2_chan_out[2] & ~opt_q[6]), $past(t2_chan_out[2] & opt_q[6])})
      else $error("channel 3 routing wrong");
   a_chan2_route: assert property ($past(hresetn) |-> {port_a_bit3, port_b_bit2} ==
      {$past(t2_chan_out[1] & ~opt_q[5]), $past(t2_chan_out[1] & opt_q[5])})
      else $error("channel 2 routing wrong");
   a_chan1_route: assert property ($past(hresetn) |-> {port_a_bit0, port_b_bit1} ==
      {$past(t2_chan_out[0] & ~opt_q[4]), $past(t2_chan_out[0] & opt_q[4])})
      else $error("channel 1 routing wrong");
   // pins pass a three-stage sync, so allow six settled cycles
   // reset must be seen high in both cycles, as the trigger flop leaves reset low
   a_trig_pclk: assert property ((hresetn && opt_q[1:0] == 2'h0) [*2] |-> t2_ext_trigger)
      else $error("pclk trigger not high");
   a_trig_slow: assert property ((opt_q[1:0] == 2'h1 && clk_1khz) [*6] |-> t2_ext_trigger)
      else $error("1 khz trigger not passed");
   a_mask_and: assert property ((opt_q[2:0] == 3'h7 && !ext_clock_mask_input) [*6]
      |-> !t2_ext_trigger) else $error("mask input not anded");
   a_mask_off: assert property ((opt_q[2:0] == 3'h3 && ext_clock_pin) [*6]
      |-> t2_ext_trigger) else $error("mask input not ignored");
endmodule // tmr_option_irq_regs_monitor

bind tmr_option_irq_regs tmr_option_irq_regs_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hwdata(hwdata), .t2_chan_out(t2_chan_out), .port_a_bit0(port_a_bit0),
   .port_a_bit1(port_a_bit1), .port_a_bit2(port_a_bit2), .port_a_bit3(port_a_bit3),
   .port_b_bit1(port_b_bit1), .port_b_bit2(port_b_bit2), .port_b_bit3(port_b_bit3),
   .port_b_bit4(port_b_bit4), .ext_clock_pin(ext_clock_pin),
   .ext_clock_mask_input(ext_clock_mask_input), .clk_1khz(clk_1khz),
   .t2_ext_trigger(t2_ext_trigger));
